// File: logic/xps_feedback_stats.sv
// Per-stream primitive statistics and captured-vertex replay front end.
`timescale 1ns/1ns
// Behaviour
// R1 - Replay issues instanced array draw, first zero, captured count, given instances.
// R2 - Missing stream selector means stream zero; missing instance count means one.
// R3 - Stored vertex count holds only vertices actually recorded to that stream.
// R4 - Replay of a capturing object uses the count from its previous end.
// R5 - Stream out of range, unknown object or negative instances give invalid value.
// R6 - Replay of an object never ended while bound gives invalid operation.
// R7 - Starting a generated query clears that stream's generated counter.
// R8 - Every stream keeps its own query and counters; stream count is fixed.
// R9 - Active generated counter counts every primitive, capture or not.
// R10 - Generated counter counts primitives after splitting at the feedback stage.
// R11 - Starting a written query clears that stream's written counter.
// R12 - Active written counter counts each primitive stored into a buffer.
// R13 - Written counter holds while capture is off or a primitive misfits.
// R14 - Starting an any-stream overflow query clears the global flag.
// R15 - During capture a misfit on any stream sets the global flag.
// R16 - Starting a stream overflow query clears only that stream's flag.
// R17 - During capture a misfit on a stream sets that stream's flag.
// R18 - A misfitting primitive stores no vertices and leaves written count alone.
// R19 - Counters and flags hold their values after the query ends.
module xps_feedback_stats
  import xps_pkg::*;
(
  input logic CLK_SYS,
  input logic RSTN,
  input logic PRIM_VALID,
  input logic [SIDX_W-1:0] PRIM_STREAM,
  input logic [VTX_W-1:0] PRIM_VERTS,
  input logic PRIM_RECORDS,
  input logic PRIM_FITS,
  input logic CAPTURE_BEGIN_CMD,
  input logic CAPTURE_END_CMD,
  input logic [OBJ_W-1:0] CAPTURE_OBJ,
  input logic CAPTURE_PAUSED,
  input logic QUERY_START_CMD,
  input logic QUERY_END_CMD,
  input xps_qkind_e QUERY_KIND,
  input logic [SIDX_W-1:0] QUERY_INDEX,
  input logic [NOBJ-1:0] OBJ_EXISTS,
  input logic CAPTURED_REPLAY_DRAW,
  input logic [OBJ_W-1:0] REPLAY_OBJ,
  input logic REPLAY_HAS_STREAM,
  input logic [SSEL_W-1:0] REPLAY_STREAM,
  input logic REPLAY_HAS_INST,
  input logic [CNT_W-1:0] REPLAY_INST,
  input logic [MODE_W-1:0] REPLAY_MODE,
  output logic REPLAY_READY,
  output logic INSTANCED_ARRAY_DRAW,
  output logic [MODE_W-1:0] DRAW_MODE,
  output logic [CNT_W-1:0] DRAW_FIRST,
  output logic [CNT_W-1:0] DRAW_COUNT,
  output logic [CNT_W-1:0] DRAW_INST,
  output logic ERR_VALID,
  output xps_err_e ERR_CODE,
  output logic CAPTURE_ACTIVE,
  output xps_cnt_t GEN_COUNT,
  output xps_cnt_t WRITTEN_COUNT,
  output logic [NSTREAM-1:0] STREAM_OVF,
  output logic ANY_OVF
);
  typedef struct packed {
    logic [NSTREAM-1:0] gen_on;
    logic [NSTREAM-1:0] wr_on;
    logic [NSTREAM-1:0] sovf_on;
    logic any_on;
    xps_cnt_t gen;
    xps_cnt_t wr;
    logic [NSTREAM-1:0] sovf;
    logic any_ovf;
    logic cap_on;
    logic [OBJ_W-1:0] cap_obj;
    xps_cnt_t cap_vtx;
    xps_rstate_e state;
    logic [SIDX_W-1:0] r_stream;
    logic [CNT_W-1:0] r_inst;
    logic [MODE_W-1:0] r_mode;
    xps_err_e r_err;
    logic ready;
    logic draw_v;
    logic [MODE_W-1:0] draw_mode;
    logic [CNT_W-1:0] draw_count;
    logic [CNT_W-1:0] draw_inst;
    logic err_v;
    xps_err_e err_code;
  } xps_top_s;

  function automatic logic [NSTREAM-1:0] onehot(
    input logic [SIDX_W-1:0] idx);
    logic [NSTREAM-1:0] v;
    v = '0;
    v[idx] = 1'b1;
    return v;
  endfunction

  // Kind and index come in as arguments so that a continuous assignment
  // that calls this wakes up on every input it depends on.
  function automatic logic [NSTREAM-1:0] query_sel(
    input logic cmd,
    input xps_qkind_e kind,
    input logic [SIDX_W-1:0] idx,
    input xps_qkind_e want);
    return (cmd && kind == want) ? onehot(idx) : '0;
  endfunction

  xps_top_s st_reg;
  xps_top_s nx;
  logic [NSTREAM-1:0] ev_hit;
  logic [NSTREAM-1:0] start_gen;
  logic [NSTREAM-1:0] start_wr;
  logic [NSTREAM-1:0] start_sovf;
  logic [NSTREAM-1:0] end_gen;
  logic [NSTREAM-1:0] end_wr;
  logic [NSTREAM-1:0] end_sovf;
  logic start_any;
  logic end_any;
  logic cap_active;
  logic replay_take;
  logic [SSEL_W-1:0] req_stream;
  logic mem_we;
  logic [WORD_W-1:0] mem_wdata;
  logic [WORD_W-1:0] mem_rdata;

  xps_ev_if ev ();

  // Pausing stops recording but keeps the capture open for replay.
  assign cap_active = st_reg.cap_on && !CAPTURE_PAUSED;

  xps_prim_classify u_classify (
    .clk_sys(CLK_SYS),
    .rstn(RSTN),
    .prim_valid(PRIM_VALID),
    .prim_stream(PRIM_STREAM),
    .prim_verts(PRIM_VERTS),
    .prim_records(PRIM_RECORDS),
    .prim_fits(PRIM_FITS),
    .cap_active(cap_active),
    .ev(ev.src)
  );

  assign ev_hit = ev.valid ? onehot(ev.stream) : '0; // R8
  assign start_gen = query_sel(QUERY_START_CMD, QUERY_KIND, QUERY_INDEX,
    QK_GEN);
  assign start_wr = query_sel(QUERY_START_CMD, QUERY_KIND, QUERY_INDEX,
    QK_WRITTEN);
  assign start_sovf = query_sel(QUERY_START_CMD, QUERY_KIND, QUERY_INDEX,
    QK_OVF_STREAM);
  assign end_gen = query_sel(QUERY_END_CMD, QUERY_KIND, QUERY_INDEX,
    QK_GEN);
  assign end_wr = query_sel(QUERY_END_CMD, QUERY_KIND, QUERY_INDEX,
    QK_WRITTEN);
  assign end_sovf = query_sel(QUERY_END_CMD, QUERY_KIND, QUERY_INDEX,
    QK_OVF_STREAM);
  assign start_any = QUERY_START_CMD && QUERY_KIND == QK_OVF_ANY;
  assign end_any = QUERY_END_CMD && QUERY_KIND == QK_OVF_ANY;

  assign replay_take = CAPTURED_REPLAY_DRAW && st_reg.ready;
  assign req_stream = REPLAY_HAS_STREAM ? REPLAY_STREAM : STREAM_DEFAULT; // R2

  // The stored word changes only at a capture end, so an object that is
  // capturing again still replays the count of its previous end.
  assign mem_we = st_reg.cap_on && CAPTURE_END_CMD; // R4
  assign mem_wdata = {1'b1, nx.cap_vtx}; // R6

  xps_cap_mem u_mem (
    .clk_sys(CLK_SYS),
    .rstn(RSTN),
    .wr_en(mem_we),
    .wr_obj(st_reg.cap_obj),
    .wr_data(mem_wdata),
    .rd_en(replay_take),
    .rd_obj(REPLAY_OBJ),
    .rd_data(mem_rdata)
  );

  always_comb
  begin
    nx = st_reg;
    nx.draw_v = 1'b0;
    nx.err_v = 1'b0;
    // A start in the same cycle as an event counts that event, so no
    // primitive is lost between clear and count.
    for (int s = 0; s < NSTREAM; s++)
    begin
      if (start_gen[s])
      begin
        nx.gen_on[s] = 1'b1;
        nx.gen[s] = ev_hit[s] ? CNT_ONE : '0; // R7
      end
      else if (st_reg.gen_on[s] && ev_hit[s])
        nx.gen[s] = st_reg.gen[s] + CNT_ONE; // R9
      if (end_gen[s])
        nx.gen_on[s] = 1'b0; // R19
      if (start_wr[s])
      begin
        nx.wr_on[s] = 1'b1;
        nx.wr[s] = (ev_hit[s] && ev.wr) ? CNT_ONE : '0; // R11
      end
      else if (st_reg.wr_on[s] && ev_hit[s] && ev.wr)
        nx.wr[s] = st_reg.wr[s] + CNT_ONE; // R12 R13
      if (end_wr[s])
        nx.wr_on[s] = 1'b0; // R19
      if (start_sovf[s])
      begin
        nx.sovf_on[s] = 1'b1;
        nx.sovf[s] = ev_hit[s] && ev.ovf; // R16
      end
      else if (st_reg.sovf_on[s] && ev_hit[s] && ev.ovf)
        nx.sovf[s] = 1'b1; // R17
      if (end_sovf[s])
        nx.sovf_on[s] = 1'b0; // R19
      if (ev_hit[s] && ev.wr)
        nx.cap_vtx[s] = st_reg.cap_vtx[s] + CNT_W'(ev.verts); // R3
    end
    if (start_any)
    begin
      nx.any_on = 1'b1;
      nx.any_ovf = ev.valid && ev.ovf; // R14
    end
    else if (st_reg.any_on && ev.valid && ev.ovf)
      nx.any_ovf = 1'b1; // R15
    if (end_any)
      nx.any_on = 1'b0; // R19
    if (CAPTURE_BEGIN_CMD && !st_reg.cap_on)
    begin
      nx.cap_on = 1'b1;
      nx.cap_obj = CAPTURE_OBJ;
      nx.cap_vtx = '0;
    end
    if (CAPTURE_END_CMD && st_reg.cap_on)
      nx.cap_on = 1'b0;
    unique case (st_reg.state)
      RS_IDLE:
      begin
        if (replay_take)
        begin
          nx.state = RS_READ;
          nx.r_mode = REPLAY_MODE;
          nx.r_stream = req_stream[SIDX_W-1:0];
          nx.r_inst = REPLAY_HAS_INST ? REPLAY_INST : INST_DEFAULT; // R2
          if (req_stream >= STREAM_LIMIT || !OBJ_EXISTS[REPLAY_OBJ] ||
              (REPLAY_HAS_INST && REPLAY_INST[CNT_W-1]))
            nx.r_err = ERR_INVALID_VALUE; // R5
          else
            nx.r_err = ERR_NONE;
        end
      end
      RS_READ:
      begin
        nx.state = RS_IDLE;
        if (st_reg.r_err != ERR_NONE)
        begin
          nx.err_v = 1'b1;
          nx.err_code = st_reg.r_err; // R5
        end
        else if (!mem_rdata[ENDED_BIT])
        begin
          nx.err_v = 1'b1;
          nx.err_code = ERR_INVALID_OP; // R6
        end
        else
        begin
          nx.draw_v = 1'b1;
          nx.draw_mode = st_reg.r_mode;
          nx.draw_inst = st_reg.r_inst; // R1
          nx.draw_count = mem_rdata[st_reg.r_stream * CNT_W +: CNT_W]; // R1
        end
      end
    endcase
    nx.ready = (nx.state == RS_IDLE);
  end

  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
      st_reg <= '0;
    else
      st_reg <= nx;
  end

  assign REPLAY_READY = st_reg.ready;
  assign INSTANCED_ARRAY_DRAW = st_reg.draw_v;
  assign DRAW_MODE = st_reg.draw_mode;
  assign DRAW_FIRST = DRAW_FIRST_VAL; // R1
  assign DRAW_COUNT = st_reg.draw_count;
  assign DRAW_INST = st_reg.draw_inst;
  assign ERR_VALID = st_reg.err_v;
  assign ERR_CODE = st_reg.err_code;
  assign CAPTURE_ACTIVE = st_reg.cap_on;
  assign GEN_COUNT = st_reg.gen;
  assign WRITTEN_COUNT = st_reg.wr;
  assign STREAM_OVF = st_reg.sovf;
  assign ANY_OVF = st_reg.any_ovf;

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RSTN);

  gen_clear_a: assert property ( // R7
    QUERY_START_CMD && QUERY_KIND == QK_GEN && !ev.valid
    |=> GEN_COUNT[$past(QUERY_INDEX)] == '0)
    else $error("generated counter not cleared by query start");
  gen_count_a: assert property ( // R9
    ev.valid && st_reg.gen_on[ev.stream] && !QUERY_START_CMD
    |=> GEN_COUNT[$past(ev.stream)] ==
        $past(GEN_COUNT[ev.stream]) + CNT_ONE)
    else $error("generated counter missed a primitive");
  wr_clear_a: assert property ( // R11
    QUERY_START_CMD && QUERY_KIND == QK_WRITTEN && !ev.valid
    |=> WRITTEN_COUNT[$past(QUERY_INDEX)] == '0)
    else $error("written counter not cleared by query start");
  wr_hold_a: assert property ( // R13
    !ev.wr && !QUERY_START_CMD |=> $stable(WRITTEN_COUNT))
    else $error("written counter moved without a stored primitive");
  wr_count_a: assert property ( // R12
    ev.valid && ev.wr && st_reg.wr_on[ev.stream] && !QUERY_START_CMD
    |=> WRITTEN_COUNT[$past(ev.stream)] ==
        $past(WRITTEN_COUNT[ev.stream]) + CNT_ONE)
    else $error("written counter missed a stored primitive");
  // Without an event or a start nothing may move, query ended or not.
  gen_hold_a: assert property ( // R19
    !ev.valid && !QUERY_START_CMD |=> $stable(GEN_COUNT))
    else $error("generated counter moved without a primitive");
  ovf_hold_a: assert property ( // R19
    !ev.ovf && !QUERY_START_CMD
    |=> $stable(STREAM_OVF) && $stable(ANY_OVF))
    else $error("overflow flag moved without a misfit");
  any_clear_a: assert property ( // R14
    start_any && !(ev.valid && ev.ovf) |=> !ANY_OVF)
    else $error("global overflow not cleared by query start");
  // A fresh start in the cycle after the set may clear the flag again.
  any_set_a: assert property ( // R15
    ev.valid && ev.ovf && st_reg.any_on ##1 !start_any |-> ANY_OVF [*2])
    else $error("global overflow not set or not held");
  stream_set_a: assert property ( // R17
    ev.valid && ev.ovf && st_reg.sovf_on[ev.stream]
    |=> STREAM_OVF[$past(ev.stream)])
    else $error("stream overflow not set");
  stream_clear_a: assert property ( // R16
    QUERY_START_CMD && QUERY_KIND == QK_OVF_STREAM && !ev.ovf
    |=> !STREAM_OVF[$past(QUERY_INDEX)])
    else $error("stream overflow not cleared by query start");
  replay_range_a: assert property ( // R5
    replay_take && REPLAY_HAS_STREAM && REPLAY_STREAM >= STREAM_LIMIT
    |-> ##2 ERR_VALID && ERR_CODE == ERR_INVALID_VALUE)
    else $error("out of range stream not refused");
  replay_inst_a: assert property ( // R2
    replay_take && !REPLAY_HAS_INST
    |-> ##2 !INSTANCED_ARRAY_DRAW || DRAW_INST == INST_DEFAULT)
    else $error("default instance count not one");
  replay_answer_a: assert property ( // R1
    replay_take |=> !REPLAY_READY ##1 (INSTANCED_ARRAY_DRAW ^ ERR_VALID)
    && REPLAY_READY)
    else $error("replay not answered in two cycles");

  draw_seen_c: cover property (INSTANCED_ARRAY_DRAW && DRAW_COUNT != '0);
  op_err_c: cover property (ERR_VALID && ERR_CODE == ERR_INVALID_OP);
  ovf_seen_c: cover property (ANY_OVF && STREAM_OVF != '0);
  busy_replay_c: cover property (INSTANCED_ARRAY_DRAW && st_reg.cap_on);
  paused_c: cover property (CAPTURE_PAUSED && PRIM_VALID && st_reg.cap_on);
endmodule

// File: logic/xps_pkg.sv
// Shared constants and types of the feedback statistics block.
package xps_pkg;
  localparam int NSTREAM = 4;
  localparam int SIDX_W = 2;
  localparam int SSEL_W = 3;
  localparam int NOBJ = 8;
  localparam int OBJ_W = 3;
  localparam int CNT_W = 32;
  localparam int VTX_W = 2;
  localparam int MODE_W = 4;
  localparam int WORD_W = NSTREAM * CNT_W + 1;
  localparam int ENDED_BIT = WORD_W - 1;
  localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;
  localparam logic [CNT_W-1:0] DRAW_FIRST_VAL = 32'h0000_0000;
  localparam logic [CNT_W-1:0] INST_DEFAULT = 32'h0000_0001;
  localparam logic [SSEL_W-1:0] STREAM_DEFAULT = 3'h0;
  localparam logic [SSEL_W-1:0] STREAM_LIMIT = 3'h4;

  typedef logic [NSTREAM-1:0][CNT_W-1:0] xps_cnt_t;

  typedef enum logic [1:0]
  {
    QK_GEN = 2'h0,
    QK_WRITTEN = 2'h1,
    QK_OVF_ANY = 2'h2,
    QK_OVF_STREAM = 2'h3
  } xps_qkind_e;

  typedef enum logic [1:0]
  {
    ERR_NONE = 2'h0,
    ERR_INVALID_VALUE = 2'h1,
    ERR_INVALID_OP = 2'h2
  } xps_err_e;

  typedef enum logic [0:0]
  {
    RS_IDLE = 1'h0,
    RS_READ = 1'h1
  } xps_rstate_e;
endpackage

// File: logic/xps_ev_if.sv
// Classified primitive event passed from the classifier to the counters.
`timescale 1ns/1ns
interface xps_ev_if;
  import xps_pkg::*;
  logic valid;
  logic [SIDX_W-1:0] stream;
  logic wr;
  logic ovf;
  logic [VTX_W-1:0] verts;
  modport src (output valid, output stream, output wr, output ovf,
    output verts);
  modport dst (input valid, input stream, input wr, input ovf,
    input verts);
endinterface

// File: logic/xps_prim_classify.sv
// Registers and classifies each incoming primitive against capture state.
`timescale 1ns/1ns
module xps_prim_classify
  import xps_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic prim_valid,
  input wire logic [SIDX_W-1:0] prim_stream,
  input wire logic [VTX_W-1:0] prim_verts,
  input wire logic prim_records,
  input wire logic prim_fits,
  input wire logic cap_active,
  xps_ev_if.src ev
);
  typedef struct packed {
    logic valid;
    logic [SIDX_W-1:0] stream;
    logic wr;
    logic ovf;
    logic [VTX_W-1:0] verts;
  } xps_cls_s;

  xps_cls_s s_reg;
  xps_cls_s s_next;
  logic rec;

  // Primitives arrive already split into separate points, lines or
  // triangles, so each valid cycle is one counted primitive.
  assign rec = prim_valid && cap_active && prim_records;

  always_comb
  begin
    s_next = s_reg;
    s_next.valid = prim_valid; // R10
    s_next.stream = prim_stream;
    s_next.wr = rec && prim_fits; // R12 R13 R18
    s_next.ovf = rec && !prim_fits; // R15 R17
    s_next.verts = (rec && prim_fits) ? prim_verts : '0; // R3 R18
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign ev.valid = s_reg.valid;
  assign ev.stream = s_reg.stream;
  assign ev.wr = s_reg.wr;
  assign ev.ovf = s_reg.ovf;
  assign ev.verts = s_reg.verts;

  no_capture_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R13
    prim_valid && !cap_active |=> !ev.wr && !ev.ovf)
    else $error("event marked written or overflow without capture");
  misfit_store_a: assert property (@(posedge clk_sys) disable iff (!rstn) // R18
    prim_valid && cap_active && prim_records && !prim_fits
    |=> ev.ovf && !ev.wr && ev.verts == '0)
    else $error("primitive that does not fit was stored");
endmodule

// File: logic/xps_cap_mem.sv
// Per-object store of captured vertex counts and a capture-ended mark.
`timescale 1ns/1ns
module xps_cap_mem
  import xps_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic wr_en,
  input wire logic [OBJ_W-1:0] wr_obj,
  input wire logic [WORD_W-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [OBJ_W-1:0] rd_obj,
  output logic [WORD_W-1:0] rd_data
);
  typedef struct packed {
    logic [NOBJ-1:0][WORD_W-1:0] mem;
    logic [WORD_W-1:0] rd;
  } xps_mem_s;

  xps_mem_s m_reg;
  xps_mem_s m_next;

  // Reset clears the ended marks so a fresh object refuses replay.
  // A read in the same cycle as a write to that object returns the old
  // word, which is the count of the previous capture end.
  always_comb
  begin
    m_next = m_reg;
    if (rd_en)
      m_next.rd = m_reg.mem[rd_obj];
    if (wr_en)
      m_next.mem[wr_obj] = wr_data;
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      m_reg <= '0;
    else
      m_reg <= m_next;
  end

  assign rd_data = m_reg.rd;
endmodule

// File: tb/xps_prim_src.sv
// Far-side model of the vertex pipeline that delivers split primitives.
`timescale 1ns/1ns
module xps_prim_src
  import xps_pkg::*;
(
  input wire logic clk,
  output logic prim_valid,
  output logic [SIDX_W-1:0] prim_stream,
  output logic [VTX_W-1:0] prim_verts,
  output logic prim_records,
  output logic prim_fits
);
  initial
  begin
    prim_valid = 1'b0;
    prim_stream = 2'h0;
    prim_verts = 2'h0;
    prim_records = 1'b0;
    prim_fits = 1'b0;
  end

  // Sends n primitives back to back. Once idle the qualifiers are inverted
  // so the block cannot lean on stale values.
  task automatic send(input logic [SIDX_W-1:0] s, input logic [VTX_W-1:0] v,
    input logic rec, input logic fit, input int n);
    for (int i = 0; i < n; i++)
    begin
      prim_valid = 1'b1;
      prim_stream = s;
      prim_verts = v;
      prim_records = rec;
      prim_fits = fit;
      @(posedge clk);
      #1;
    end
    prim_valid = 1'b0;
    prim_stream = ~s;
    prim_verts = ~v;
    prim_records = ~rec;
    prim_fits = ~fit;
  endtask
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the feedback statistics and replay block.
`timescale 1ns/1ns
module tb_top;
  import xps_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic p_valid, p_rec, p_fits;
  logic [SIDX_W-1:0] p_stream;
  logic [VTX_W-1:0] p_verts;
  logic cap_b = 1'b0;
  logic cap_e = 1'b0;
  logic [OBJ_W-1:0] cap_obj = 3'h0;
  logic qs = 1'b0;
  logic qe = 1'b0;
  xps_qkind_e qkind = QK_GEN;
  logic [SIDX_W-1:0] qidx = 2'h0;
  logic [NOBJ-1:0] obj_ex = 8'h0F;
  logic rq = 1'b0;
  logic [OBJ_W-1:0] r_obj = 3'h0;
  logic r_hs = 1'b0;
  logic r_hi = 1'b0;
  logic [SSEL_W-1:0] r_s = 3'h0;
  logic [CNT_W-1:0] r_n = 32'h0;
  logic [MODE_W-1:0] r_md = 4'h0;
  logic cap_p = 1'b0;
  logic rdy, dr, ev, cap_act, aovf;
  logic [MODE_W-1:0] d_mode;
  logic [CNT_W-1:0] d_first, d_cnt, d_inst;
  xps_err_e ecode;
  xps_cnt_t gen, wrn;
  logic [NSTREAM-1:0] sovf;
  int failures = 0;
  int cmp_count = 0;

  always #2 clk_sys = ~clk_sys;

  xps_prim_src u_xps_prim_src (.clk(clk_sys), .prim_valid(p_valid),
    .prim_stream(p_stream), .prim_verts(p_verts), .prim_records(p_rec),
    .prim_fits(p_fits));

  xps_feedback_stats u_xps_feedback_stats (.CLK_SYS(clk_sys), .RSTN(rstn),
    .PRIM_VALID(p_valid), .PRIM_STREAM(p_stream), .PRIM_VERTS(p_verts),
    .PRIM_RECORDS(p_rec), .PRIM_FITS(p_fits), .CAPTURE_BEGIN_CMD(cap_b),
    .CAPTURE_END_CMD(cap_e), .CAPTURE_OBJ(cap_obj), .CAPTURE_PAUSED(cap_p),
    .QUERY_START_CMD(qs), .QUERY_END_CMD(qe), .QUERY_KIND(qkind),
    .QUERY_INDEX(qidx), .OBJ_EXISTS(obj_ex), .CAPTURED_REPLAY_DRAW(rq),
    .REPLAY_OBJ(r_obj), .REPLAY_HAS_STREAM(r_hs), .REPLAY_STREAM(r_s),
    .REPLAY_HAS_INST(r_hi), .REPLAY_INST(r_n), .REPLAY_MODE(r_md),
    .REPLAY_READY(rdy), .INSTANCED_ARRAY_DRAW(dr), .DRAW_MODE(d_mode),
    .DRAW_FIRST(d_first), .DRAW_COUNT(d_cnt), .DRAW_INST(d_inst),
    .ERR_VALID(ev), .ERR_CODE(ecode), .CAPTURE_ACTIVE(cap_act),
    .GEN_COUNT(gen), .WRITTEN_COUNT(wrn), .STREAM_OVF(sovf), .ANY_OVF(aovf));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wcy(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1)
    begin
      failures++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask

  // Each command pulse is followed by an idle cycle so calls can chain.
  task automatic qcmd(input logic st, input xps_qkind_e k,
    input logic [SIDX_W-1:0] i);
    qkind = k;
    qidx = i;
    qs = st;
    qe = !st;
    wcy(1);
    qs = 1'b0;
    qe = 1'b0;
    wcy(1);
  endtask

  task automatic ccmd(input logic b, input logic [OBJ_W-1:0] o);
    cap_obj = o;
    cap_b = b;
    cap_e = !b;
    wcy(1);
    cap_b = 1'b0;
    cap_e = 1'b0;
    wcy(1);
  endtask

  task automatic rp(input logic [OBJ_W-1:0] o, input logic hs,
    input logic [SSEL_W-1:0] s, input logic hi, input logic [CNT_W-1:0] n,
    input xps_err_e ec, input logic [CNT_W-1:0] xc,
    input logic [CNT_W-1:0] xi);
    int k;
    k = 0;
    while (rdy !== 1'b1 && k < 20)
    begin
      wcy(1);
      k++;
    end
    r_obj = o;
    r_hs = hs;
    r_s = s;
    r_hi = hi;
    r_n = n;
    r_md = {1'b0, o};
    rq = 1'b1;
    wcy(1);
    rq = 1'b0;
    r_obj = ~o;
    r_s = ~s;
    r_n = ~n;
    r_md = {1'b1, ~o};
    chk(rdy === 1'b0, "ready held during replay");
    // The answer pulse stands only in the cycle after the busy cycle.
    wcy(1);
    if (ec === ERR_NONE)
      chk(dr === 1'b1 && ev === 1'b0 && d_first === 32'h0 && d_cnt === xc
        && d_inst === xi && d_mode === {1'b0, o} && rdy === 1'b1,
        "replay draw mismatch");
    else
      chk(ev === 1'b1 && dr === 1'b0 && ecode === ec && rdy === 1'b1,
        "replay error mismatch");
  endtask

  task automatic t_gen();
    qcmd(1'b1, QK_GEN, 2'h1);
    u_xps_prim_src.send(2'h1, 2'h1, 1'b0, 1'b1, 3);
    u_xps_prim_src.send(2'h2, 2'h2, 1'b0, 1'b1, 1);
    wcy(2);
    chk(gen[1] === 32'h3, "generated count");
    chk(gen[2] === 32'h0, "idle stream counted");
    qcmd(1'b0, QK_GEN, 2'h1);
    u_xps_prim_src.send(2'h1, 2'h1, 1'b0, 1'b1, 2);
    wcy(2);
    chk(gen[1] === 32'h3, "count moved after end");
    qcmd(1'b1, QK_GEN, 2'h1);
    chk(gen[1] === 32'h0, "generated not cleared");
  endtask

  task automatic t_cap();
    qcmd(1'b1, QK_WRITTEN, 2'h0);
    qcmd(1'b1, QK_OVF_ANY, 2'h0);
    qcmd(1'b1, QK_OVF_STREAM, 2'h0);
    qcmd(1'b1, QK_OVF_STREAM, 2'h1);
    u_xps_prim_src.send(2'h0, 2'h3, 1'b1, 1'b0, 1);
    u_xps_prim_src.send(2'h0, 2'h3, 1'b1, 1'b1, 1);
    wcy(2);
    chk(wrn[0] === 32'h0, "written without capture");
    chk(aovf === 1'b0 && sovf === 4'h0, "overflow without capture");
    ccmd(1'b1, 3'h2);
    chk(cap_act === 1'b1, "capture not active");
    cap_p = 1'b1;
    u_xps_prim_src.send(2'h0, 2'h3, 1'b1, 1'b0, 1);
    u_xps_prim_src.send(2'h0, 2'h3, 1'b1, 1'b1, 1);
    cap_p = 1'b0;
    wcy(2);
    chk(wrn[0] === 32'h0 && aovf === 1'b0 && sovf === 4'h0,
      "recorded while paused");
    u_xps_prim_src.send(2'h0, 2'h3, 1'b1, 1'b1, 2);
    u_xps_prim_src.send(2'h0, 2'h3, 1'b1, 1'b0, 1);
    u_xps_prim_src.send(2'h1, 2'h2, 1'b1, 1'b0, 1);
    u_xps_prim_src.send(2'h0, 2'h2, 1'b0, 1'b1, 1);
    wcy(2);
    chk(wrn[0] === 32'h2, "written count");
    chk(aovf === 1'b1, "any overflow not set");
    chk(sovf === 4'h3, "stream overflow flags");
    qcmd(1'b1, QK_OVF_STREAM, 2'h1);
    chk(sovf === 4'h1, "stream flag clear");
    qcmd(1'b1, QK_OVF_ANY, 2'h0);
    chk(aovf === 1'b0, "any flag clear");
    qcmd(1'b1, QK_WRITTEN, 2'h0);
    chk(wrn[0] === 32'h0, "written not cleared");
    ccmd(1'b0, 3'h2);
    chk(cap_act === 1'b0, "capture still active");
  endtask

  task automatic t_rep();
    rp(3'h2, 1'b1, 3'h0, 1'b1, 32'h5, ERR_NONE, 32'h6, 32'h5);
    rp(3'h2, 1'b0, 3'h3, 1'b0, 32'h9, ERR_NONE, 32'h6, 32'h1);
    rp(3'h2, 1'b1, 3'h1, 1'b0, 32'h0, ERR_NONE, 32'h0, 32'h1);
    rp(3'h2, 1'b1, 3'h4, 1'b1, 32'h1, ERR_INVALID_VALUE, 32'h0, 32'h0);
    rp(3'h6, 1'b0, 3'h0, 1'b0, 32'h1, ERR_INVALID_VALUE, 32'h0, 32'h0);
    rp(3'h2, 1'b0, 3'h0, 1'b1, 32'hFFFF_FFFF, ERR_INVALID_VALUE, 32'h0,
      32'h0);
    rp(3'h3, 1'b0, 3'h0, 1'b0, 32'h1, ERR_INVALID_OP, 32'h0, 32'h0);
    ccmd(1'b1, 3'h2);
    u_xps_prim_src.send(2'h0, 2'h1, 1'b1, 1'b1, 2);
    wcy(2);
    rp(3'h2, 1'b0, 3'h0, 1'b0, 32'h0, ERR_NONE, 32'h6, 32'h1);
    ccmd(1'b0, 3'h2);
    rp(3'h2, 1'b0, 3'h0, 1'b0, 32'h0, ERR_NONE, 32'h2, 32'h1);
  endtask

  // The whole sequence needs well under a thousand cycles.
  initial
  begin
    #(5000 * 4);
    failures++;
    end_of_test();
  end

  initial
  begin
    repeat (8) @(posedge clk_sys);
    #1;
    rstn = 1'b1;
    wcy(2);
    t_gen();
    t_cap();
    t_rep();
    end_of_test();
  end
endmodule
